// *** pkg/prst_pkg.sv ***
`default_nettype none
package prst_pkg;
	// Avalon word offsets (byte addresses)
	localparam logic [7:0] PRST_OFS_KEY = 8'h00;
	localparam logic [7:0] PRST_OFS_DATA = 8'h04;
	localparam logic [7:0] PRST_OFS_DIR = 8'h08;
	localparam logic [7:0] PRST_OFS_ANSEL = 8'h0C;
	localparam logic [7:0] PRST_OFS_I2C = 8'h10;
	localparam logic [7:0] PRST_OFS_ADCH = 8'h14;
	localparam logic [7:0] PRST_OFS_BITOP = 8'h18;
	localparam logic [7:0] PRST_OFS_WAKEEN = 8'h1C;
	localparam logic [7:0] PRST_OFS_STAT = 8'h20;
	localparam logic [7:0] PRST_OFS_MASK = 8'h24;
	localparam logic [7:0] PRST_OFS_SLEEP = 8'h28;
	localparam logic [7:0] PRST_KEY_PATTERN = 8'hCA;
	localparam logic [7:0] PRST_KEY_RST = 8'h00;
	localparam logic [7:0] PRST_PORT_RST = 8'hFF;
	localparam logic [31:0] PRST_UNMAPPED = 32'h0000_0000;
	// Bit-op register fields
	localparam int PRST_BOP_IDX_LSB = 0;
	localparam int PRST_BOP_VAL_BIT = 3;
	localparam int PRST_BOP_SEL_BIT = 4;
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} prst_req_t;
	typedef enum logic [2:0] {
		PRST_IDLE = 3'b001,
		PRST_ACK = 3'b010,
		PRST_RMW = 3'b100
	} prst_state_t;
endpackage
`default_nettype wire

// *** rtl/prst_port.sv ***
`default_nettype none
module prst_port
	import prst_pkg::*;
#(
	parameter int W = 8
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe,
	input wire logic [W-1:0] fn_select,
	input wire logic [W-1:0] fn_out,
	input wire logic [W-1:0] fn_oe,
	output logic [W-1:0] converter_channel_inputs,
	output logic readback_enable_internal,
	output logic wake_req,
	output logic irq
);
	localparam int CW = $clog2(W);
	prst_req_t req;
	prst_state_t state_q;
	logic [7:0] readback_key_q;
	logic rb_q;
	logic [W-1:0] data_q, dir_q, ansel_q, i2c_q, wakeen_q;
	logic [CW-1:0] adch_q;
	logic [W-1:0] sync1_q, sync2_q, prev_q;
	logic [W-1:0] read_val;
	logic [W-1:0] rmw_q;
	logic [7:0] bop_q;
	logic stat_q, mask_q, sleep_q;
	logic [31:0] rdata_d;
	logic wr_key, wr_data, wr_dir, wr_bop, fall_ev;
	logic [W-1:0] rmw_new;

	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// Idle at pull-up level, no false edge
			sync1_q <= '1;
			sync2_q <= '1;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// Per-bit port read value
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_rd
			always_comb
			begin
				if (rb_q)
					read_val[g] = sync2_q[g];
				else if (ansel_q[g])
					read_val[g] = 1'b0;
				else if (i2c_q[g] || dir_q[g])
					read_val[g] = i2c_q[g] ? sync2_q[g] : 1'b0;
				else
					read_val[g] = data_q[g];
			end
		end
	endgenerate

	// Bus state machine; bit ops take an extra cycle
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			state_q <= PRST_IDLE;
		else
		begin
			case (state_q)
				PRST_IDLE:
				begin
					if (req.write && req.address == PRST_OFS_BITOP)
						state_q <= PRST_RMW;
					else if (req.read || req.write)
						state_q <= PRST_ACK;
				end
				PRST_RMW: state_q <= PRST_ACK;
				PRST_ACK: state_q <= PRST_IDLE;
				default: state_q <= PRST_IDLE;
			endcase
		end
	end

	always_comb
	begin
		wr_key = (state_q == PRST_ACK) && req.write && req.address == PRST_OFS_KEY;
		wr_data = (state_q == PRST_ACK) && req.write && req.address == PRST_OFS_DATA;
		wr_dir = (state_q == PRST_ACK) && req.write && req.address == PRST_OFS_DIR;
		wr_bop = (state_q == PRST_ACK) && req.write && req.address == PRST_OFS_BITOP;
		rmw_new = rmw_q;
		rmw_new[bop_q[PRST_BOP_IDX_LSB +: CW]] = bop_q[PRST_BOP_VAL_BIT];
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(state_q == PRST_RMW || (state_q == PRST_IDLE
				&& (req.read || req.write) && !(req.write && req.address == PRST_OFS_BITOP)));
	end

	// Key register and enable decode
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			readback_key_q <= PRST_KEY_RST;
			rb_q <= 1'b0;
		end
		else if (wr_key)
		begin
			readback_key_q <= req.writedata[7:0];
			rb_q <= (req.writedata[7:0] == PRST_KEY_PATTERN);
		end
	end

	// Read-modify-write capture: whole port, or DIR when the select bit is set, read first
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rmw_q <= '0;
			bop_q <= '0;
		end
		else if (state_q == PRST_IDLE && req.write && req.address == PRST_OFS_BITOP)
		begin
			bop_q <= req.writedata[7:0];
			rmw_q <= req.writedata[PRST_BOP_SEL_BIT] ? dir_q : read_val;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			data_q <= {W{1'b1}};
			dir_q <= {W{1'b1}};
		end
		else
		begin
			if (wr_data)
				data_q <= req.writedata[W-1:0];
			else if (wr_bop && !bop_q[PRST_BOP_SEL_BIT])
				data_q <= rmw_new;
			if (wr_dir)
				dir_q <= req.writedata[W-1:0];
			else if (wr_bop && bop_q[PRST_BOP_SEL_BIT])
				dir_q <= rmw_new;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			ansel_q <= '0;
			i2c_q <= '0;
			adch_q <= '0;
			wakeen_q <= '0;
			mask_q <= 1'b0;
			sleep_q <= 1'b0;
		end
		else if (state_q == PRST_ACK && req.write)
		begin
			case (req.address)
				PRST_OFS_ANSEL: ansel_q <= req.writedata[W-1:0];
				PRST_OFS_I2C: i2c_q <= req.writedata[W-1:0];
				PRST_OFS_ADCH: adch_q <= req.writedata[CW-1:0];
				PRST_OFS_WAKEEN: wakeen_q <= req.writedata[W-1:0];
				PRST_OFS_MASK: mask_q <= req.writedata[0];
				PRST_OFS_SLEEP: sleep_q <= req.writedata[0];
				default: ;
			endcase
		end
	end

	// Wake on falling edge of enabled pins while asleep
	always_comb
		fall_ev = sleep_q && |(wakeen_q & prev_q & ~sync2_q);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			prev_q <= '1;
			stat_q <= 1'b0;
			wake_req <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			prev_q <= sync2_q;
			wake_req <= fall_ev;
			if (fall_ev)
				stat_q <= 1'b1;
			else if (state_q == PRST_ACK && req.write && req.address == PRST_OFS_STAT
				&& req.writedata[0])
				stat_q <= 1'b0;
			irq <= (stat_q || fall_ev) && mask_q && !(state_q == PRST_ACK && req.write
				&& req.address == PRST_OFS_STAT && req.writedata[0] && !fall_ev);
		end
	end

	// Pin drive and converter paths
	generate
		for (g = 0; g < W; g++)
		begin : g_pin
			always_ff @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					pin_out[g] <= 1'b1;
					pin_oe[g] <= 1'b0;
					converter_channel_inputs[g] <= 1'b0;
				end
				else
				begin
					pin_out[g] <= fn_select[g] ? fn_out[g] : data_q[g];
					pin_oe[g] <= fn_select[g] ? fn_oe[g] : !dir_q[g];
					converter_channel_inputs[g] <= ansel_q[g]
						|| (rb_q && adch_q == CW'(g));
				end
			end
		end
	endgenerate

	always_comb
	begin
		case (req.address)
			PRST_OFS_KEY: rdata_d = {24'h0000_00, readback_key_q};
			PRST_OFS_DATA: rdata_d = 32'(read_val);
			PRST_OFS_DIR: rdata_d = 32'(dir_q);
			PRST_OFS_ANSEL: rdata_d = 32'(ansel_q);
			PRST_OFS_I2C: rdata_d = 32'(i2c_q);
			PRST_OFS_ADCH: rdata_d = 32'(adch_q);
			PRST_OFS_BITOP: rdata_d = {24'h0000_00, bop_q};
			PRST_OFS_WAKEEN: rdata_d = 32'(wakeen_q);
			PRST_OFS_STAT: rdata_d = {31'h0000_0000, stat_q};
			PRST_OFS_MASK: rdata_d = {31'h0000_0000, mask_q};
			PRST_OFS_SLEEP: rdata_d = {31'h0000_0000, sleep_q};
			default: rdata_d = PRST_UNMAPPED;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			avs_readdata <= '0;
		else if (state_q != PRST_ACK && req.read)
			avs_readdata <= rdata_d;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			readback_enable_internal <= 1'b0;
		else if (wr_key)
			readback_enable_internal <= (req.writedata[7:0] == PRST_KEY_PATTERN);
	end

	AST_KEY_ENABLE: assert property (@(posedge ref_clk) disable iff (reset)
		wr_key |=> rb_q == ($past(req.writedata[7:0]) == PRST_KEY_PATTERN)
			&& readback_enable_internal == rb_q)
		else $error("Readback enable mismatches key");
	AST_KEY_READBACK: assert property (@(posedge ref_clk) disable iff (reset)
		wr_key |=> readback_key_q == $past(req.writedata[7:0]))
		else $error("Key not stored");
	AST_RB_PIN: assert property (@(posedge ref_clk) disable iff (reset)
		rb_q |-> read_val == sync2_q)
		else $error("Readback not pin level");
	AST_DIR_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
		!rb_q |-> ((dir_q & ~i2c_q & read_val) == '0))
		else $error("Input pin read nonzero");
	AST_LATCH: assert property (@(posedge ref_clk) disable iff (reset)
		!rb_q |-> ((~dir_q & ~ansel_q & ~i2c_q & (read_val ^ data_q)) == '0))
		else $error("Output pin not latch value");
	AST_CONV: assert property (@(posedge ref_clk) disable iff (reset)
		!rb_q && !$past(rb_q) && $past(ansel_q) == '0 |-> converter_channel_inputs == '0)
		else $error("Converter path open");
	AST_FORCE: assert property (@(posedge ref_clk) disable iff (reset)
		rb_q |=> converter_channel_inputs[$past(adch_q)])
		else $error("Converter path not forced");
	AST_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
		fall_ev |=> wake_req && stat_q)
		else $error("Wake missed");
	AST_PIN_DRIVE: assert property (@(posedge ref_clk) disable iff (reset)
		!fn_select[0] |=> pin_out[0] == $past(data_q[0]))
		else $error("Pin drive wrong");
endmodule
`default_nettype wire

// *** tb/prst_pins.sv ***
`default_nettype none
module prst_pins(
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up wherever neither side drives
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule
`default_nettype wire

// *** tb/port_readback_self_test_test.sv ***
`default_nettype none
module port_readback_self_test_test
	import prst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] fn_select = 8'h00;
	logic [7:0] fn_out = 8'h00;
	logic [7:0] fn_oe = 8'h00;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] conv;
	logic rb_en;
	logic wake_req;
	logic irq;
	logic [31:0] q;
	logic [3:0] wake_seen = 4'h0;
	int fail_count = 0;
	int samples_checked = 0;

	always #20 ref_clk = ~ref_clk;

	// Counts wake pulses, which stand one cycle only
	always @(posedge ref_clk)
		if (wake_req === 1'b1)
			wake_seen <= wake_seen + 4'h1;

	prst_port #(.W(8)) dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .fn_select(fn_select), .fn_out(fn_out),
		.fn_oe(fn_oe), .converter_channel_inputs(conv), .readback_enable_internal(rb_en),
		.wake_req(wake_req), .irq(irq));

	prst_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do
		begin
			@(posedge ref_clk);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask

	initial
	begin
		repeat (2000) @(posedge ref_clk);
		fail_count++;
		complete_run();
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		rd(PRST_OFS_KEY, 32'h0000_0000);
		rd(PRST_OFS_DIR, 32'h0000_00FF);
		wr(PRST_OFS_DIR, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		chk({16'h0000, pin_oe, pin_out}, 32'h0000_FFFF);
		rd(PRST_OFS_DATA, 32'h0000_00FF);
		wr(PRST_OFS_BITOP, 32'h0000_0002);
		rd(PRST_OFS_DATA, 32'h0000_00FB);
		wr(PRST_OFS_BITOP, 32'h0000_001F);
		rd(PRST_OFS_DIR, 32'h0000_0080);
		rd(PRST_OFS_DATA, 32'h0000_007B);
		wr(PRST_OFS_KEY, 32'h0000_00CB);
		rd(PRST_OFS_KEY, 32'h0000_00CB);
		chk({31'h0, rb_en}, 32'h0000_0000);
		wr(PRST_OFS_KEY, 32'h0000_00CA);
		rd(PRST_OFS_KEY, 32'h0000_00CA);
		chk({31'h0, rb_en}, 32'h0000_0001);
		rd(PRST_OFS_DATA, 32'h0000_00FB);
		wr(PRST_OFS_ADCH, 32'h0000_0003);
		repeat (2) @(posedge ref_clk);
		chk({24'h0, conv}, 32'h0000_0008);
		wr(PRST_OFS_KEY, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		chk({24'h0, conv}, 32'h0000_0000);
		wr(PRST_OFS_ANSEL, 32'h0000_0001);
		rd(PRST_OFS_DATA, 32'h0000_007A);
		chk({24'h0, conv}, 32'h0000_0001);
		wr(PRST_OFS_I2C, 32'h0000_0080);
		rd(PRST_OFS_DATA, 32'h0000_00FA);
		// Shared function takes pin 0 over
		fn_select <= 8'h01;
		repeat (3) @(posedge ref_clk);
		chk({30'h0, pin_oe[0], pin_out[0]}, 32'h0000_0000);
		fn_select <= 8'h00;
		ext_en <= 8'h01;
		ext_val <= 8'h01;
		wr(PRST_OFS_DIR, 32'h0000_00FF);
		wr(PRST_OFS_WAKEEN, 32'h0000_0001);
		wr(PRST_OFS_MASK, 32'h0000_0000);
		wr(PRST_OFS_SLEEP, 32'h0000_0001);
		repeat (4) @(posedge ref_clk);
		ext_val <= 8'h00;
		repeat (6) @(posedge ref_clk);
		rd(PRST_OFS_STAT, 32'h0000_0001);
		chk({28'h0, wake_seen}, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(PRST_OFS_MASK, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(PRST_OFS_STAT, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(PRST_OFS_STAT, 32'h0000_0000);
		wr(8'h3C, 32'h0000_00FF);
		rd(8'h3C, PRST_UNMAPPED);
		complete_run();
	end
endmodule
`default_nettype wire
